/* pkg/tws_pkg.sv */
// Package: register map, field positions and state codes of the two-wire controller
package tws_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [11:0] TWS_ADDR_CTRL = 12'h000;
   localparam logic [11:0] TWS_ADDR_STAT = 12'h004;
   localparam logic [11:0] TWS_ADDR_MASK = 12'h008;
   localparam logic [11:0] TWS_ADDR_OWN = 12'h00c;
   localparam logic [11:0] TWS_ADDR_TX = 12'h010;
   localparam logic [11:0] TWS_ADDR_RX = 12'h014;
   localparam logic [11:0] TWS_ADDR_BAUD = 12'h018;
   // ----------------------------------------
   // Control field positions
   // ----------------------------------------
   localparam int TWS_C_START = 0;
   localparam int TWS_C_RSTART = 1;
   localparam int TWS_C_STOP = 2;
   localparam int TWS_C_RCV = 3;
   localparam int TWS_C_ACKSEQ = 4;
   localparam int TWS_C_ACKVAL = 5;
   localparam int TWS_C_STRETCH = 6;
   localparam int TWS_C_GENERAL_CALL_ENABLE = 7;
   localparam int TWS_C_TEN = 10;
   localparam int TWS_C_PMM = 11;
   localparam int TWS_C_RELEASE = 12;
   localparam int TWS_C_EN = 15;
   // ----------------------------------------
   // Status field positions
   // ----------------------------------------
   localparam int TWS_S_TBF = 0;
   localparam int TWS_S_RBF = 1;
   localparam int TWS_S_RW = 2;
   localparam int TWS_S_START = 3;
   localparam int TWS_S_STOP = 4;
   localparam int TWS_S_DA = 5;
   localparam int TWS_S_OV = 6;
   localparam int TWS_S_WCOL = 7;
   localparam int TWS_S_TEN = 8;
   localparam int TWS_S_GC = 9;
   localparam int TWS_S_BCL = 10;
   localparam int TWS_S_TRS = 14;
   localparam int TWS_S_ACK = 15;
   // ----------------------------------------
   // Reset values and counts
   // ----------------------------------------
   localparam logic [15:0] TWS_CTRL_RST = 16'h1000;
   localparam logic [15:0] TWS_BAUD_RST = 16'h0009;
   localparam logic [3:0] TWS_BITS_BYTE = 4'h8;
   // Master sequencer states
   typedef enum logic [3:0] {
      TWS_M_IDLE = 4'b0000,
      TWS_M_START = 4'b0001,
      TWS_M_RSTART = 4'b0010,
      TWS_M_STOP = 4'b0011,
      TWS_M_TX = 4'b0100,
      TWS_M_RX = 4'b0101,
      TWS_M_ACK = 4'b0110
   } tws_mst_t;
endpackage

/* verilog/tws_ctrl.sv */
// Two-wire bus controller: master sequencer, slave receiver, status and mask logic
// How it works
// - Master acknowledge drives the chosen ack value: 1 is NACK, 0 is ACK.
// - Ack request runs an acknowledge slot, cleared by hardware when done.
// - Receive enable clocks in a byte, cleared after the eighth bit.
// - Stop request makes a Stop, cleared when it completes.
// - Repeated start request makes a Repeated Start, cleared when done.
// - Start request makes a Start, cleared at its end.
// - Ack status flag updated at each transmit ack slot end: 1 NACK, 0 ACK.
// - Master tx status set at transmit start, cleared after slave ack.
// - Bus collision in master operation sets a flag software clears.
// - General call flag set on general call match, cleared at Stop.
// - Ten-bit match flag is never set (no ten-bit addressing), cleared at Stop.
// - Transmit write while busy is dropped and sets write collision flag.
// - Byte done while receive register full sets overflow flag.
// - Data-or-address flag clears on address match, sets on each data byte the slave receives.
// - Start and Stop detections update start-seen and stop-seen flags.
// - Slave records direction bit of each received address byte.
// - Receive full set on load, cleared on software read.
// - Transmit full set on software write, cleared when sent.
// - Mask bits set to 1 exclude address bits from comparison.
// - Reserved addresses never match the own address, whatever the mask.
// - General call acknowledged only when general call enable is 1.
// - Masking applies only while platform management mode is off.
// - With stretching on, software and receive may hold clock low.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/10ps
module tws_ctrl
   import tws_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] stat;
      logic [9:0] mask;
      logic [9:0] own;
      logic [15:0] baud;
      logic [7:0] tx;
      logic [7:0] rx;
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_d;
      logic sda_d;
      tws_mst_t mst;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [15:0] cnt;
      logic scl_lo;
      logic sda_lo;
      logic [3:0] sbit;
      logic [7:0] ssh;
      logic [1:0] sst;
      logic slv_sda_lo;
      logic [31:0] rdata;
   } tws_st_t;

   tws_st_t s_r, s_nxt;

   // Address match: masking off in management mode, reserved codes never match
   function automatic logic addr_match(input logic [6:0] a, input logic [9:0] own,
                                       input logic [9:0] msk, input logic pmm);
      logic [6:0] m;
      logic rsv;
      // Management mode answers every non-reserved address, so the mask is moot there
      m = pmm ? 7'h00 : msk[6:0];
      rsv = (a[6:3] == 4'h0) || (a[6:3] == 4'hf);
      addr_match = !rsv && (pmm || (((a ^ own[6:0]) & ~m) == 7'h00));
   endfunction

   logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det, tick, busy;
   logic wr, rd;

   // Line edges and conditions, seen only through the second flop
   always_comb begin
      scl_f = s_r.scl_s[1];
      sda_f = s_r.sda_s[1];
      scl_rise = scl_f && !s_r.scl_d;
      scl_fall = !scl_f && s_r.scl_d;
      start_det = scl_f && s_r.scl_d && !sda_f && s_r.sda_d;
      stop_det = scl_f && s_r.scl_d && sda_f && !s_r.sda_d;
      tick = (s_r.cnt == 16'h0000);
      busy = (s_r.mst != TWS_M_IDLE) || s_r.stat[TWS_S_TRS];
      wr = psel && penable && pwrite;
      rd = psel && penable && !pwrite;
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      // Two-flop synchronisers; only the second stage is looked at
      s_nxt.scl_s = {s_r.scl_s[0], scl_i};
      s_nxt.sda_s = {s_r.sda_s[0], sda_i};
      s_nxt.scl_d = scl_f;
      s_nxt.sda_d = sda_f;
      s_nxt.cnt = tick ? s_r.baud : s_r.cnt - 16'h0001;

      // Software clears of flags first so that hardware sets below win
      // Writing 0 clears a flag, writing 1 leaves it alone
      if (wr && paddr == TWS_ADDR_STAT) begin
         if (!pwdata[TWS_S_BCL]) s_nxt.stat[TWS_S_BCL] = 1'b0;
         if (!pwdata[TWS_S_WCOL]) s_nxt.stat[TWS_S_WCOL] = 1'b0;
         if (!pwdata[TWS_S_OV]) s_nxt.stat[TWS_S_OV] = 1'b0;
      end
      if (wr && paddr == TWS_ADDR_CTRL) begin
         s_nxt.ctrl = pwdata[15:0] & 16'hbcff;
         // Without stretch enable the release bit may only be set
         if (!s_r.ctrl[TWS_C_STRETCH] && !pwdata[TWS_C_RELEASE])
            s_nxt.ctrl[TWS_C_RELEASE] = s_r.ctrl[TWS_C_RELEASE];
      end
      if (wr && paddr == TWS_ADDR_MASK) s_nxt.mask = pwdata[9:0];
      if (wr && paddr == TWS_ADDR_OWN) s_nxt.own = pwdata[9:0];
      if (wr && paddr == TWS_ADDR_BAUD) s_nxt.baud = pwdata[15:0];
      if (rd && paddr == TWS_ADDR_RX) s_nxt.stat[TWS_S_RBF] = 1'b0;
      if (wr && paddr == TWS_ADDR_TX) begin
         if (busy) begin
            // The byte is dropped; the one on the line goes on
            s_nxt.stat[TWS_S_WCOL] = 1'b1;
         end else begin
            s_nxt.tx = pwdata[7:0];
            s_nxt.stat[TWS_S_TBF] = 1'b1;
            s_nxt.stat[TWS_S_TRS] = 1'b1;
            s_nxt.mst = TWS_M_TX;
            s_nxt.sh = pwdata[7:0];
            s_nxt.bitn = 4'h0;
            s_nxt.ph = 2'b00;
         end
      end

      // Bus condition detection
      // Conditions from any master also restart the slave receiver
      if (start_det) begin
         s_nxt.stat[TWS_S_START] = 1'b1;
         s_nxt.stat[TWS_S_STOP] = 1'b0;
         s_nxt.sst = 2'b01;
         s_nxt.sbit = 4'h0;
      end
      if (stop_det) begin
         s_nxt.stat[TWS_S_STOP] = 1'b1;
         s_nxt.stat[TWS_S_START] = 1'b0;
         s_nxt.stat[TWS_S_GC] = 1'b0;
         s_nxt.stat[TWS_S_TEN] = 1'b0;
         s_nxt.sst = 2'b00;
      end

      // Master sequencer, one phase per baud tick
      // Requests wait in the control register until the sequencer is idle
      if (s_r.mst == TWS_M_IDLE && s_r.ctrl[TWS_C_EN]) begin
         s_nxt.ph = 2'b00;
         s_nxt.bitn = 4'h0;
         if (s_r.ctrl[TWS_C_START]) s_nxt.mst = TWS_M_START;
         else if (s_r.ctrl[TWS_C_RSTART]) s_nxt.mst = TWS_M_RSTART;
         else if (s_r.ctrl[TWS_C_STOP]) s_nxt.mst = TWS_M_STOP;
         else if (s_r.ctrl[TWS_C_RCV]) s_nxt.mst = TWS_M_RX;
         else if (s_r.ctrl[TWS_C_ACKSEQ]) s_nxt.mst = TWS_M_ACK;
      end else if (tick) begin
         s_nxt.ph = s_r.ph + 2'b01;
         case (s_r.mst)
            TWS_M_START: begin
               // SDA falls while SCL high, then SCL falls
               if (s_r.ph == 2'b01) s_nxt.sda_lo = 1'b1;
               if (s_r.ph == 2'b10) s_nxt.scl_lo = 1'b1;
               if (s_r.ph == 2'b10) begin
                  s_nxt.ctrl[TWS_C_START] = 1'b0;
                  s_nxt.mst = TWS_M_IDLE;
               end
            end

            // Free data, lift clock, then data falls with clock high
            TWS_M_RSTART: begin
               if (s_r.ph == 2'b00) s_nxt.sda_lo = 1'b0;
               if (s_r.ph == 2'b01) s_nxt.scl_lo = 1'b0;
               if (s_r.ph == 2'b10) s_nxt.sda_lo = 1'b1;
               if (s_r.ph == 2'b11) begin
                  s_nxt.scl_lo = 1'b1;
                  s_nxt.ctrl[TWS_C_RSTART] = 1'b0;
                  s_nxt.mst = TWS_M_IDLE;
               end
            end

            // Hold data low, lift clock, then data rises with clock high
            TWS_M_STOP: begin
               if (s_r.ph == 2'b00) s_nxt.sda_lo = 1'b1;
               if (s_r.ph == 2'b01) s_nxt.scl_lo = 1'b0;
               if (s_r.ph == 2'b10) s_nxt.sda_lo = 1'b0;
               if (s_r.ph == 2'b11) begin
                  s_nxt.ctrl[TWS_C_STOP] = 1'b0;
                  s_nxt.mst = TWS_M_IDLE;
               end
            end

            TWS_M_TX, TWS_M_RX, TWS_M_ACK: begin
               // Phase 0 sets data with SCL low, 1 lifts SCL, 2 samples, 3 drops SCL
               if (s_r.ph == 2'b00) begin
                  if (s_r.mst == TWS_M_TX)
                     s_nxt.sda_lo = (s_r.bitn < TWS_BITS_BYTE) ? !s_r.sh[7] : 1'b0;
                  else if (s_r.mst == TWS_M_ACK)
                     s_nxt.sda_lo = !s_r.ctrl[TWS_C_ACKVAL];
                  else
                     s_nxt.sda_lo = 1'b0;
               end
               if (s_r.ph == 2'b01) s_nxt.scl_lo = 1'b0;
               if (s_r.ph == 2'b10) begin
                  s_nxt.sh = {s_r.sh[6:0], sda_f};
                  s_nxt.bitn = s_r.bitn + 4'h1;
               end
               if (s_r.ph == 2'b11) begin
                  s_nxt.scl_lo = 1'b1;
                  if (s_r.mst == TWS_M_ACK) begin
                     s_nxt.ctrl[TWS_C_ACKSEQ] = 1'b0;
                     // Data is kept while the clock falls: a release on this edge
                     // could look like a Stop; the next sequence frees it
                     s_nxt.mst = TWS_M_IDLE;
                  end else if (s_r.mst == TWS_M_RX && s_r.bitn == TWS_BITS_BYTE) begin
                     s_nxt.ctrl[TWS_C_RCV] = 1'b0;
                     s_nxt.mst = TWS_M_IDLE;
                     if (s_r.stat[TWS_S_RBF]) begin
                        s_nxt.stat[TWS_S_OV] = 1'b1;
                     end else begin
                        s_nxt.rx = s_r.sh;
                        s_nxt.stat[TWS_S_RBF] = 1'b1;
                     end
                  end else if (s_r.mst == TWS_M_TX && s_r.bitn == TWS_BITS_BYTE + 4'h1) begin
                     // Ninth bit is the slave's acknowledge, read back into sh
                     s_nxt.stat[TWS_S_ACK] = s_r.sh[0];
                     s_nxt.stat[TWS_S_TRS] = 1'b0;
                     s_nxt.stat[TWS_S_TBF] = 1'b0;
                     s_nxt.sda_lo = 1'b0;
                     s_nxt.mst = TWS_M_IDLE;
                  end
               end
            end

            default: s_nxt.mst = TWS_M_IDLE;
         endcase
      end

      // Collision: released SDA read low while master drives the bus
      // Looked at only with the clock seen high; the ack bit is the slave's
      if (s_r.mst != TWS_M_IDLE && !s_r.sda_lo && !s_r.scl_lo && scl_f && !sda_f
          && s_r.ph == 2'b10 && !(s_r.mst == TWS_M_TX && s_r.bitn == TWS_BITS_BYTE)
          && s_r.mst != TWS_M_RX && s_r.mst != TWS_M_ACK) begin
         s_nxt.stat[TWS_S_BCL] = 1'b1;
         s_nxt.mst = TWS_M_IDLE;
         s_nxt.sda_lo = 1'b0;
         s_nxt.scl_lo = 1'b0;
         s_nxt.ctrl[4:0] = 5'h00;
         s_nxt.stat[TWS_S_TRS] = 1'b0;
         s_nxt.stat[TWS_S_TBF] = 1'b0;
      end

      // Slave receiver: 0 idle, 1 address, 2 data, 3 ack slot
      // Listens only: slave transmit and ten-bit addresses are left out
      if (s_r.sst != 2'b00 && !start_det && !stop_det) begin
         if (scl_rise && s_r.sst != 2'b11) begin
            s_nxt.ssh = {s_r.ssh[6:0], sda_f};
            s_nxt.sbit = s_r.sbit + 4'h1;
         end
         if (scl_fall && s_r.sbit == TWS_BITS_BYTE && s_r.sst != 2'b11) begin
            s_nxt.sbit = 4'h0;
            if (s_r.sst == 2'b01) begin
               s_nxt.stat[TWS_S_RW] = s_r.ssh[0];
               if (s_r.ssh == 8'h00 && s_r.ctrl[TWS_C_GENERAL_CALL_ENABLE]) begin
                  s_nxt.stat[TWS_S_GC] = 1'b1;
                  s_nxt.stat[TWS_S_DA] = 1'b0;
                  s_nxt.slv_sda_lo = 1'b1;
                  s_nxt.sst = 2'b11;
               end else if (addr_match(s_r.ssh[7:1], s_r.own, s_r.mask,
                                       s_r.ctrl[TWS_C_PMM])) begin
                  s_nxt.stat[TWS_S_DA] = 1'b0;
                  s_nxt.slv_sda_lo = 1'b1;
                  s_nxt.sst = 2'b11;
               end else begin
                  s_nxt.sst = 2'b00;
               end
            end else begin
               s_nxt.stat[TWS_S_DA] = 1'b1;
               if (s_r.stat[TWS_S_RBF]) begin
                  s_nxt.stat[TWS_S_OV] = 1'b1;
               end else begin
                  s_nxt.rx = s_r.ssh;
                  s_nxt.stat[TWS_S_RBF] = 1'b1;
                  s_nxt.slv_sda_lo = 1'b1;
               end
               // Receive stretch: hold clock until software releases it
               if (s_r.ctrl[TWS_C_STRETCH]) s_nxt.ctrl[TWS_C_RELEASE] = 1'b0;
               s_nxt.sst = 2'b11;
            end
         end
         if (scl_fall && s_r.sst == 2'b11) begin
            s_nxt.slv_sda_lo = 1'b0;
            s_nxt.sst = 2'b10;
         end
      end

      // Read data is latched in the setup phase, so the access phase
      // needs no wait state and pready can stay high
      if (paddr == TWS_ADDR_CTRL) s_nxt.rdata = {16'h0000, s_r.ctrl};
      else if (paddr == TWS_ADDR_STAT) s_nxt.rdata = {16'h0000, s_r.stat};
      else if (paddr == TWS_ADDR_MASK) s_nxt.rdata = {22'h000000, s_r.mask};
      else if (paddr == TWS_ADDR_OWN) s_nxt.rdata = {22'h000000, s_r.own};
      else if (paddr == TWS_ADDR_TX) s_nxt.rdata = {24'h000000, s_r.tx};
      else if (paddr == TWS_ADDR_RX) s_nxt.rdata = {24'h000000, s_r.rx};
      else if (paddr == TWS_ADDR_BAUD) s_nxt.rdata = {16'h0000, s_r.baud};
      else s_nxt.rdata = 32'h00000000;

      // Disabled block drops sequencer, slave and line activity
      // Registers keep their contents so software can still look at them
      if (!s_r.ctrl[TWS_C_EN]) begin
         s_nxt.mst = TWS_M_IDLE;
         s_nxt.sda_lo = 1'b0;
         s_nxt.scl_lo = 1'b0;
         s_nxt.sst = 2'b00;
         s_nxt.slv_sda_lo = 1'b0;
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.ctrl <= TWS_CTRL_RST;
         s_r.baud <= TWS_BAUD_RST;
         // Line copies start at the idle high level, so no false edge follows
         s_r.scl_s <= 2'b11;
         s_r.sda_s <= 2'b11;
         s_r.scl_d <= 1'b1;
         s_r.sda_d <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Open-drain: output always low, enable pulls the line
   // The clock hold is a level, so software and receive stretch share one bit
   always_comb begin
      prdata = s_r.rdata;
      pready = 1'b1;
      pslverr = 1'b0;
      scl_o = 1'b0;
      sda_o = 1'b0;
      scl_oe = s_r.scl_lo || (s_r.ctrl[TWS_C_EN] && !s_r.ctrl[TWS_C_RELEASE]);
      sda_oe = s_r.sda_lo || s_r.slv_sda_lo;
   end
endmodule

/* dv/tws_ctrl_properties.sv */
// Checker: port-level properties of the two-wire controller
`timescale 1ns/10ps
module tws_ctrl_properties
   import tws_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe
);
   // ----------------------------------------
   // Properties on the bus and line pins
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic ctl_wr;
   logic rd_setup;
   // Enabled control write, and a read setup phase
   assign ctl_wr = psel && penable && pwrite && paddr == TWS_ADDR_CTRL && pwdata[TWS_C_EN];
   assign rd_setup = psel && !penable && !pwrite;
   a_bus_answer:
      assert property (psel && penable |-> pready && !pslverr) else $error("access not clean");
   a_open_drain:
      assert property (!scl_o && !sda_o) else $error("line driven high");
   a_mask_width:
      assert property (rd_setup && paddr == TWS_ADDR_MASK |=> prdata[31:10] == 22'h0)
      else $error("mask reads back above bit 9");
   a_mask_store:
      assert property (psel && penable && pwrite && paddr == TWS_ADDR_MASK ##2
         rd_setup && paddr == TWS_ADDR_MASK |=> prdata[9:0] == $past(pwdata[9:0], 3))
      else $error("mask not stored");
   a_start_cond:
      assert property (ctl_wr && (pwdata[TWS_C_START] || pwdata[TWS_C_RSTART]) |->
         ##[1:300] ($rose(sda_oe) && !scl_oe)) else $error("no start condition");
   a_stop_cond:
      assert property (ctl_wr && pwdata[TWS_C_STOP] |-> ##[1:300] ($fell(sda_oe) && !scl_oe))
      else $error("no stop condition");
   a_ack_drive:
      assert property (ctl_wr && pwdata[TWS_C_ACKSEQ] && !pwdata[TWS_C_ACKVAL] |->
         ##[1:300] sda_oe) else $error("ack not driven");
   a_nack_release:
      assert property (ctl_wr && pwdata[TWS_C_ACKSEQ] && pwdata[TWS_C_ACKVAL] |=>
         !sda_oe [*8]) else $error("nack pulled data low");
   a_rx_release:
      assert property (ctl_wr && pwdata[TWS_C_RCV] |-> ##[1:40] !sda_oe [*8])
      else $error("receive pulled data low");
   a_collision_idle:
      assert property (psel && penable && !pwrite && paddr == TWS_ADDR_STAT &&
         prdata[TWS_S_BCL] |-> !scl_oe && !sda_oe) else $error("lines held after collision");
endmodule

/* dv/tws_bus_model.sv */
// Bus model: an addressed slave that acks written bytes and serves a read byte
`timescale 1ns/10ps
module tws_bus_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic [7:0] rd_byte,
   input wire logic collide,
   output logic sda_pull
);
   // ----------------------------------------
   // Frame tracking on the line levels
   // ----------------------------------------
   logic [3:0] bit_cnt = 4'h0;
   logic [7:0] shift_r = 8'h0;
   logic addr_byte = 1'b0;
   logic reading = 1'b0;
   logic drive = 1'b0;
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   // A commanded collision pulls data low whatever the frame does
   assign sda_pull = drive | collide;
   // One process owns the frame state; the last levels tell which line moved
   always @(scl or sda) begin
      if (scl === 1'b1 && scl_q !== 1'b1) begin
         // Bits are taken on the rising clock
         shift_r = {shift_r[6:0], sda};
         bit_cnt = bit_cnt + 4'h1;
      end else if (scl !== 1'b1 && scl_q === 1'b1) begin
         // Data only moves on the falling clock; a master nack ends the read
         if (bit_cnt == 4'h8) begin
            drive = addr_byte | ~reading;
            if (addr_byte) reading = shift_r[0];
            addr_byte = 1'b0;
         end else begin
            if (bit_cnt == 4'h9) begin
               bit_cnt = 4'h0;
               reading = reading & ~shift_r[0];
            end
            drive = reading & ~rd_byte[3'h7 - bit_cnt[2:0]];
         end
      end else if (scl === 1'b1 && sda !== sda_q) begin
         // Data moving with clock high is a start or a stop, so the frame restarts
         bit_cnt = 4'h0;
         addr_byte = ~sda;
         reading = 1'b0;
         drive = 1'b0;
      end
      scl_q = scl;
      sda_q = sda;
   end
endmodule

/* dv/testbench.sv */
// Testbench: register-level scenarios of the two-wire controller against a bus model
`timescale 1ns/10ps
module testbench
   import tws_pkg::*;
;
   // Control word with enable and clock release set
   localparam logic [31:0] CTL = 32'h00009000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic scl_o, scl_oe, sda_o, sda_oe, scl_w, sda_w, sda_pull, collide;
   logic [7:0] rd_byte;
   int n_mismatch, n_compared;
   // Pull-ups on both lines; only the controller pulls the clock low, either party may pull data low
   assign scl_w = scl_oe ? scl_o : 1'b1;
   assign sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
   always #4 pclk = ~pclk;
   tws_ctrl tws_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe)
   );
   tws_bus_model tws_bus_model_inst (
      .scl(scl_w), .sda(sda_w), .rd_byte(rd_byte), .collide(collide), .sda_pull(sda_pull)
   );
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One transfer; the request stands until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic look(input string name, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] want);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      check(name, q & m, want);
   endtask
   // Line timing is slow next to the bus, so flags are polled with a bound
   task automatic poll(input string name, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] want);
      logic [31:0] q;
      for (int i = 0; i < 400; i++) begin
         apb(1'b0, a, 32'h0, q);
         if ((q & m) === want) break;
      end
      check(name, q & m, want);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      look("ctrl reset", TWS_ADDR_CTRL, 32'hffffffff, {16'h0, TWS_CTRL_RST});
      look("status reset", TWS_ADDR_STAT, 32'hffffffff, 32'h0);
      wr(TWS_ADDR_MASK, 32'hffffffff);
      look("mask width", TWS_ADDR_MASK, 32'hffffffff, 32'h000003ff);
      wr(TWS_ADDR_MASK, 32'h0);
      look("unmapped", 12'h01c, 32'hffffffff, 32'h0);
      // Reload 3 gives a 128 ns bit, close to the 125 ns link period
      wr(TWS_ADDR_BAUD, 32'h3);
      $display("test regs done");
   endtask
   task automatic t_write;
      wr(TWS_ADDR_CTRL, CTL | 32'h1);
      poll("start clears", TWS_ADDR_CTRL, 32'h1, 32'h0);
      poll("start seen", TWS_ADDR_STAT, 32'h18, 32'h8);
      wr(TWS_ADDR_TX, 32'h54);
      poll("tx busy", TWS_ADDR_STAT, 32'h4001, 32'h4001);
      wr(TWS_ADDR_TX, 32'h11);
      look("write collision", TWS_ADDR_STAT, 32'h80, 32'h80);
      poll("tx done", TWS_ADDR_STAT, 32'h4001, 32'h0);
      look("slave ack", TWS_ADDR_STAT, 32'h8000, 32'h0);
      wr(TWS_ADDR_STAT, 32'h0);
      look("wcol cleared", TWS_ADDR_STAT, 32'h80, 32'h0);
      $display("test write done");
   endtask
   task automatic t_read;
      wr(TWS_ADDR_CTRL, CTL | 32'h2);
      poll("rstart clears", TWS_ADDR_CTRL, 32'h2, 32'h0);
      wr(TWS_ADDR_TX, 32'h55);
      poll("addr sent", TWS_ADDR_STAT, 32'h4000, 32'h0);
      look("direction read", TWS_ADDR_STAT, 32'h4, 32'h4);
      wr(TWS_ADDR_CTRL, CTL | 32'h8);
      poll("rcv clears", TWS_ADDR_CTRL, 32'h8, 32'h0);
      poll("rx full", TWS_ADDR_STAT, 32'h2, 32'h2);
      wr(TWS_ADDR_CTRL, CTL | 32'h10);
      poll("ack clears", TWS_ADDR_CTRL, 32'h10, 32'h0);
      wr(TWS_ADDR_CTRL, CTL | 32'h8);
      poll("rcv again", TWS_ADDR_CTRL, 32'h8, 32'h0);
      poll("overflow", TWS_ADDR_STAT, 32'h40, 32'h40);
      look("rx byte", TWS_ADDR_RX, 32'hff, {24'h0, rd_byte});
      look("rx emptied", TWS_ADDR_STAT, 32'h2, 32'h0);
      wr(TWS_ADDR_CTRL, CTL | 32'h30);
      poll("nack clears", TWS_ADDR_CTRL, 32'h10, 32'h0);
      wr(TWS_ADDR_CTRL, CTL | 32'h4);
      poll("stop clears", TWS_ADDR_CTRL, 32'h4, 32'h0);
      poll("stop seen", TWS_ADDR_STAT, 32'h18, 32'h10);
      wr(TWS_ADDR_STAT, 32'h0);
      $display("test read done");
   endtask
   task automatic t_collide;
      wr(TWS_ADDR_CTRL, CTL | 32'h1);
      poll("start again", TWS_ADDR_CTRL, 32'h1, 32'h0);
      collide <= 1'b1;
      wr(TWS_ADDR_TX, 32'hff);
      poll("collision", TWS_ADDR_STAT, 32'h400, 32'h400);
      check("lines freed", {30'h0, scl_oe, sda_oe}, 32'h0);
      collide <= 1'b0;
      wr(TWS_ADDR_STAT, 32'h0);
      look("collision cleared", TWS_ADDR_STAT, 32'h400, 32'h0);
      $display("test collide done");
   endtask
   // Main sequence: 20 cycles of reset, then the scenarios
   initial begin
      {pclk, presetn, psel, penable, pwrite, collide} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      rd_byte = 8'ha5;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_write();
      t_read();
      t_collide();
      end_of_test();
   end
   // Watchdog: the scenarios need well under 25k cycles
   initial begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
endmodule
bind tws_ctrl tws_ctrl_properties tws_ctrl_properties_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe)
);
